/* File: src/ir_steer_cfg.svh */
/*
 * Timing counts and reset levels for the infrared output steering block.
 * Assumes a 50 MHz system clock on clk_i.
 */
`ifndef IR_STEER_CFG_SVH
`define IR_STEER_CFG_SVH

`define CLK_PERIOD_NS      20
`define DATA_WIDTH         16
`define ADDR_WIDTH         4
`define IRQ_IDLE_LEVEL     1'h1
`define TX_RESET_LEVEL     1'h0

`endif

/* File: src/ir_steer_pkg.sv */
/*
 * Types shared by the infrared output steering block.
 * Assumes the constants header is included by the users of this package.
 */
package ir_steer_pkg;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT
    } pwr_state_t;
endpackage : ir_steer_pkg

/* File: src/ir_output_steering.sv */
/*
 * Pin-level steering of the infrared transmit outputs, the host data bus
 * enable and the two active-low interrupt request pins.
 * Assumes every input is synchronous to clk_i and that the framing and
 * remote-control engines deliver their waveforms and interrupt conditions.
 */
`timescale 1ns/100ps
`include "ir_steer_cfg.svh"

// How it works
// - Main output: link, or remote when selected.
// - Remote pin carries remote when select low.
// - Pass-through mode routes external input out.
// - Link interrupt pin low while condition exists.
// - Remote interrupt pin low while condition exists.
// - Strobes count only while chip select low.
// - Reset returns all state to initial values.
// - Power-down holds wait state, outputs idle.
// - After reset interrupts high, outputs low, bus input.
module ir_output_steering
    import ir_steer_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     srst_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     power_down_n_i,
    input  wire logic                     link_tx_i,
    input  wire logic                     remote_tx_i,
    input  wire logic                     external_passthrough_in_i,
    input  wire logic                     passthrough_mode_bit_i,
    input  wire logic                     remote_control_enable_i,
    input  wire logic                     remote_output_select_i,
    input  wire logic                     aux_control_i,
    input  wire logic                     link_irq_cond_i,
    input  wire logic                     remote_irq_cond_i,
    input  wire logic                     cs_n_i,
    input  wire logic                     rd_n_i,
    input  wire logic                     wr_n_i,
    input  wire logic [`ADDR_WIDTH-1:0]   addr_i,
    input  wire logic [`DATA_WIDTH-1:0]   rd_data_i,
    input  wire logic [`DATA_WIDTH-1:0]   data_in_i,
    output logic [`DATA_WIDTH-1:0]        data_out_o,
    output logic                          data_oe_o,
    output logic                          read_strobe_o,
    output logic                          write_strobe_o,
    output logic [`ADDR_WIDTH-1:0]        write_addr_o,
    output logic [`DATA_WIDTH-1:0]        write_data_o,
    output logic                          main_transmit_out_o,
    output logic                          remote_transmit_out_o,
    output logic                          aux_control_out_o,
    output logic                          link_irq_n_o,
    output logic                          remote_irq_n_o,
    output logic                          sda_oe_o,
    output logic                          sleeping_o
);

    // ********************************************************************
    // Power and reset state
    // ********************************************************************
    pwr_state_t             state;
    pwr_state_t             next_state;
    logic                   main_tx;
    logic                   next_main_tx;
    logic                   remote_tx;
    logic                   next_remote_tx;
    logic                   aux_ctl;
    logic                   next_aux_ctl;
    logic                   link_irq_n;
    logic                   next_link_irq_n;
    logic                   remote_irq_n;
    logic                   next_remote_irq_n;
    logic [`DATA_WIDTH-1:0] rd_q;
    logic [`DATA_WIDTH-1:0] next_rd_q;
    logic                   rd_act;
    logic                   next_rd_act;
    logic                   wr_act;
    logic                   next_wr_act;
    logic                   wr_stb;
    logic                   next_wr_stb;
    logic [`ADDR_WIDTH-1:0] wr_addr;
    logic [`ADDR_WIDTH-1:0] next_wr_addr;
    logic [`DATA_WIDTH-1:0] wr_data;
    logic [`DATA_WIDTH-1:0] next_wr_data;

    logic in_reset;
    logic running;
    logic sel_rd;
    logic sel_wr;

    assign in_reset = srst_i | ~reset_n_i;
    assign running  = (state == ST_RUN) & power_down_n_i;
    assign sel_rd   = ~cs_n_i & ~rd_n_i;
    assign sel_wr   = ~cs_n_i & ~wr_n_i;

    always_comb begin
        next_state        = power_down_n_i ? ST_RUN : ST_WAIT;
        next_main_tx      = `TX_RESET_LEVEL;
        next_remote_tx    = `TX_RESET_LEVEL;
        next_aux_ctl      = aux_control_i;
        next_link_irq_n   = ~link_irq_cond_i;
        next_remote_irq_n = ~remote_irq_cond_i;
        if (passthrough_mode_bit_i) begin
            // Pass-through follows the same output choice as the remote path.
            if (remote_control_enable_i && !remote_output_select_i) begin
                next_remote_tx = external_passthrough_in_i;
            end else begin
                next_main_tx = external_passthrough_in_i;
            end
        end else if (!remote_control_enable_i) begin
            next_main_tx = link_tx_i;
        end else if (remote_output_select_i) begin
            next_main_tx = remote_tx_i;
        end else begin
            next_remote_tx = remote_tx_i;
        end
        next_rd_act  = sel_rd & running;
        next_rd_q    = sel_rd ? rd_data_i : rd_q;
        next_wr_act  = sel_wr;
        next_wr_stb  = sel_wr & ~wr_act & running;
        next_wr_addr = (sel_wr & ~wr_act) ? addr_i : wr_addr;
        next_wr_data = (sel_wr & ~wr_act) ? data_in_i : wr_data;
        if (!running) begin
            // Outputs idle while waiting so the emitter draws no current.
            next_main_tx      = `TX_RESET_LEVEL;
            next_remote_tx    = `TX_RESET_LEVEL;
            next_aux_ctl      = `TX_RESET_LEVEL;
            next_link_irq_n   = `IRQ_IDLE_LEVEL;
            next_remote_irq_n = `IRQ_IDLE_LEVEL;
        end
    end

    always_ff @(posedge clk_i) begin
        if (in_reset) begin
            state        <= ST_RUN;
            main_tx      <= `TX_RESET_LEVEL;
            remote_tx    <= `TX_RESET_LEVEL;
            aux_ctl      <= `TX_RESET_LEVEL;
            link_irq_n   <= `IRQ_IDLE_LEVEL;
            remote_irq_n <= `IRQ_IDLE_LEVEL;
            rd_q         <= 16'h0000;
            rd_act       <= 1'h0;
            wr_act       <= 1'h0;
            wr_stb       <= 1'h0;
            wr_addr      <= 4'h0;
            wr_data      <= 16'h0000;
        end else begin
            state        <= next_state;
            main_tx      <= next_main_tx;
            remote_tx    <= next_remote_tx;
            aux_ctl      <= next_aux_ctl;
            link_irq_n   <= next_link_irq_n;
            remote_irq_n <= next_remote_irq_n;
            rd_q         <= next_rd_q;
            rd_act       <= next_rd_act;
            wr_act       <= next_wr_act;
            wr_stb       <= next_wr_stb;
            wr_addr      <= next_wr_addr;
            wr_data      <= next_wr_data;
        end
    end

    // ********************************************************************
    // Pin drivers
    // ********************************************************************
    // The enable is gated live by the strobes so the bus is released the
    // moment the host lets go, not a cycle later.
    assign data_oe_o             = rd_act & sel_rd & ~in_reset;
    assign data_out_o            = rd_q;
    assign read_strobe_o         = sel_rd & ~rd_act & running;
    assign write_strobe_o        = wr_stb;
    assign write_addr_o          = wr_addr;
    assign write_data_o          = wr_data;
    assign main_transmit_out_o   = main_tx;
    assign remote_transmit_out_o = remote_tx;
    assign aux_control_out_o     = aux_ctl;
    assign link_irq_n_o          = link_irq_n;
    assign remote_irq_n_o        = remote_irq_n;
    assign sda_oe_o              = 1'h0;
    assign sleeping_o            = ~running;

    // ********************************************************************
    // Checks
    // ********************************************************************
    a_main_link_path: assert property (@(posedge clk_i) disable iff (in_reset)
        running && power_down_n_i && !passthrough_mode_bit_i && !remote_control_enable_i
        |=> main_transmit_out_o == $past(link_tx_i))
        else $error("main output does not follow link path");
    // The first cycle after power-down still idles the outputs, so the
    // routing checks key on running rather than on the pin alone.
    a_main_remote_path: assert property (@(posedge clk_i) disable iff (in_reset)
        running && !passthrough_mode_bit_i && remote_control_enable_i
        && remote_output_select_i |=> main_transmit_out_o == $past(remote_tx_i))
        else $error("main output does not follow remote path");
    a_remote_pin_path: assert property (@(posedge clk_i) disable iff (in_reset)
        running && !passthrough_mode_bit_i && remote_control_enable_i
        && !remote_output_select_i
        |=> remote_transmit_out_o == $past(remote_tx_i) && !main_transmit_out_o)
        else $error("remote pin does not follow remote path");
    a_passthrough_route: assert property (@(posedge clk_i) disable iff (in_reset)
        running && passthrough_mode_bit_i |=> (main_transmit_out_o
        | remote_transmit_out_o) == $past(external_passthrough_in_i))
        else $error("pass-through input not routed");
    a_link_irq_level: assert property (@(posedge clk_i) disable iff (in_reset)
        running |=> link_irq_n_o == !$past(link_irq_cond_i))
        else $error("link interrupt pin wrong level");
    a_remote_irq_level: assert property (@(posedge clk_i) disable iff (in_reset)
        running |=> remote_irq_n_o == !$past(remote_irq_cond_i))
        else $error("remote interrupt pin wrong level");
    a_write_needs_cs: assert property (@(posedge clk_i) disable iff (in_reset)
        write_strobe_o |-> $past(!cs_n_i && !wr_n_i))
        else $error("write strobe without chip select");
    a_reset_levels: assert property (@(posedge clk_i)
        $past(in_reset) |-> link_irq_n_o && remote_irq_n_o && !main_transmit_out_o
        && !remote_transmit_out_o && !aux_control_out_o && !data_oe_o)
        else $error("outputs not at reset levels");
    a_power_down_idle: assert property (@(posedge clk_i) disable iff (in_reset)
        !power_down_n_i |=> !main_transmit_out_o && !remote_transmit_out_o
        && link_irq_n_o && !data_oe_o)
        else $error("outputs active during power-down");
    a_bus_release: assert property (@(posedge clk_i)
        data_oe_o |-> !cs_n_i && !rd_n_i && !sda_oe_o)
        else $error("data bus driven outside selected read");
    a_read_capture: assert property (@(posedge clk_i) disable iff (in_reset)
        $rose(rd_act) |-> data_out_o == $past(rd_data_i))
        else $error("read data not captured at start of read");

endmodule : ir_output_steering

/* File: testbench/host_bus_model.sv */
/* Host CPU model that drives the block's chip select, strobes, address and data.
   Assumes the bench calls bus_cycle; the pins move only on falling clock edges. */
`timescale 1ns/100ps
`include "ir_steer_cfg.svh"
module host_bus_model (
    input  wire logic                   clk_i,
    input  wire logic [`DATA_WIDTH-1:0] data_out_i,
    input  wire logic                   data_oe_i,
    output logic                        cs_n_o = 1'h1,
    output logic                        rd_n_o = 1'h1,
    output logic                        wr_n_o = 1'h1,
    output logic [`ADDR_WIDTH-1:0]      addr_o = 4'h0,
    output logic [`DATA_WIDTH-1:0]      data_o = 16'h0000
);
    task automatic bus_cycle(input logic cs, input logic rd, input logic [3:0] a,
                             input logic [15:0] d, output logic [15:0] q, output logic oe);
        @(negedge clk_i);
        cs_n_o = !cs;
        rd_n_o = !rd;
        wr_n_o = rd;
        addr_o = a;
        data_o = d;
        @(negedge clk_i);
        q = data_out_i;
        oe = data_oe_i;
        cs_n_o = 1'h1;
        rd_n_o = 1'h1;
        wr_n_o = 1'h1;
        // Released lines show the inverse, so a late capture cannot match by chance.
        addr_o = ~a;
        data_o = ~d;
        #1;
    endtask : bus_cycle
endmodule : host_bus_model

/* File: testbench/testbench.sv */
/* Self-checking bench for the infrared output steering block and its host bus.
   Assumes the design sources and the host bus model are compiled before it. */
`timescale 1ns/100ps
`include "ir_steer_cfg.svh"
module testbench;
    logic clk_i = 1'h0, srst_i = 1'h1, reset_n_i = 1'h1, power_down_n_i = 1'h1, pt_i = 1'h0;
    logic link_tx_i = 1'h0, remote_tx_i = 1'h0, ext_i = 1'h0, en_i = 1'h0, sel_i = 1'h0;
    logic aux_i = 1'h0, lcond_i = 1'h0, rcond_i = 1'h0, cs_n, rd_n, wr_n, oe_on;
    logic data_oe_o, read_strobe_o, write_strobe_o, main_o, remote_o, aux_o, sda_oe_o;
    logic link_irq_n_o, remote_irq_n_o, sleeping_o;
    logic [`ADDR_WIDTH-1:0] addr, write_addr_o;
    logic [`DATA_WIDTH-1:0] data_in, data_out_o, write_data_o, q, rd_data_i = 16'hA5C3;
    int fail_count = 0;
    int num_checks = 0;
    int rd_pulses = 0;
    always #10 clk_i = ~clk_i;
    // Counted at the edge that ends the strobe, before its register update lands.
    always @(posedge clk_i) rd_pulses <= rd_pulses + int'(read_strobe_o);
    ir_output_steering u_ir_output_steering (.clk_i, .srst_i, .reset_n_i, .power_down_n_i,
        .link_tx_i, .remote_tx_i, .external_passthrough_in_i(ext_i),
        .passthrough_mode_bit_i(pt_i), .remote_control_enable_i(en_i),
        .remote_output_select_i(sel_i), .aux_control_i(aux_i), .link_irq_cond_i(lcond_i),
        .remote_irq_cond_i(rcond_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .addr_i(addr), .rd_data_i, .data_in_i(data_in), .data_out_o, .data_oe_o,
        .read_strobe_o, .write_strobe_o, .write_addr_o, .write_data_o,
        .main_transmit_out_o(main_o), .remote_transmit_out_o(remote_o),
        .aux_control_out_o(aux_o), .link_irq_n_o, .remote_irq_n_o, .sda_oe_o, .sleeping_o);
    host_bus_model u_host_bus_model (.clk_i, .data_out_i(data_out_o), .data_oe_i(data_oe_o),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .data_o(data_in));

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // The chosen source carries v and every other source !v, so a wrong route shows.
    task automatic steer_and_irq();
        logic [5:0] cfg [5] = '{6'h35, 6'h24, 6'h00, 6'h1A, 6'h13};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_i);
            {pt_i, en_i, sel_i} = cfg[i/2][5:3];
            link_tx_i = (cfg[i/2][2:1] == 2'h0) ~^ i[0];
            remote_tx_i = (cfg[i/2][2:1] == 2'h1) ~^ i[0];
            ext_i = (cfg[i/2][2:1] == 2'h2) ~^ i[0];
            {lcond_i, rcond_i} = {i[0], !i[0]};
            @(negedge clk_i);
            chk(cfg[i/2][0] ? remote_o : main_o, i[0]);
            chk({link_irq_n_o, remote_irq_n_o}, {!i[0], i[0]});
        end
    endtask : steer_and_irq

    task automatic bus_check(input logic cs, input logic rd, input logic [3:0] a,
                             input logic [15:0] d);
        int base = rd_pulses;
        u_host_bus_model.bus_cycle(cs, rd, a, d, q, oe_on);
        chk(20'(rd_pulses - base), 20'(cs & rd));
        chk({write_strobe_o, oe_on, data_oe_o}, {cs & !rd, cs & rd, 1'h0});
        if (cs & !rd) chk({write_addr_o, write_data_o}, {a, d});
        if (cs & rd) chk(q, rd_data_i);
        @(negedge clk_i);
        chk(write_strobe_o, 1'h0);
    endtask : bus_check

    task automatic power_down_then_reset();
        @(negedge clk_i);
        {pt_i, en_i, link_tx_i, lcond_i, rcond_i, aux_i} = 6'h0F;
        power_down_n_i = 1'h0;
        u_host_bus_model.bus_cycle(1'h1, 1'h0, 4'h3, 16'h1234, q, oe_on);
        chk({write_strobe_o, main_o, aux_o, link_irq_n_o, remote_irq_n_o, sleeping_o},
            6'h07);
        power_down_n_i = 1'h1;
        reset_n_i = 1'h0;
        @(negedge clk_i);
        chk({link_irq_n_o, aux_o}, 2'h2);
        chk({write_addr_o, write_data_o}, 20'h00000);
        reset_n_i = 1'h1;
        @(negedge clk_i);
        chk({main_o, link_irq_n_o, aux_o}, 3'h5);
    endtask : power_down_then_reset

    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (8) @(negedge clk_i);
        srst_i = 1'h0;
        @(negedge clk_i);
        chk({main_o, remote_o, aux_o, link_irq_n_o, remote_irq_n_o, data_oe_o, sda_oe_o},
            7'h0C);
        steer_and_irq();
        bus_check(1'h1, 1'h0, 4'hA, 16'h5A3C);
        bus_check(1'h1, 1'h0, 4'h5, 16'hC3A5);
        bus_check(1'h0, 1'h0, 4'hF, 16'hFFFF);
        bus_check(1'h1, 1'h1, 4'h6, 16'h0F0F);
        bus_check(1'h0, 1'h1, 4'h6, 16'h0F0F);
        power_down_then_reset();
        tally_and_finish();
    end

    // The tests need under a hundred cycles; two thousand leaves ample margin.
    initial begin
        #40000;
        fail_count++;
        tally_and_finish();
    end
endmodule : testbench
